// >>> rtl/pscp_port_ctl.sv
// Purpose : Port control and logical unit parameter pages with transport timers
// Assumes : Event inputs other than drive_ready and cmd_active are one-cycle pulses synchronous to clk; those two are levels
// Notes   : Registers reached over AXI4-Lite, one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module pscp_port_ctl (
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Link and transport events
    input  wire logic        arb_start,
    input  wire logic        conn_opened,
    input  wire logic        rej_retry,
    input  wire logic        rej_continue,
    input  wire logic        rej_absent,
    input  wire logic        xfer_rdy_sent,
    input  wire logic        data_frame_rx,
    input  wire logic        async_event_req,
    input  wire logic        drive_ready,
    input  wire logic        cmd_active,
    // Outputs
    output logic [15:0]      arb_wait_time,
    output logic             nexus_lost,
    output logic             cmd_abort,
    output logic             conn_req_allow,
    output logic             async_event_send,
    output logic             ready_led
);
    import pscp_pkg::*;

    pscp_tick_if tk ();

    pscp_tick_gen u_tick (
        .clk (clk),
        .rst (rst),
        .tk  (tk)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            OFS_PORT_HDR, OFS_PORT_TIME, OFS_PORT_HOLD, OFS_PORT_RSVD,
            OFS_LU_PAGE, OFS_STATUS, OFS_ARB_TIMER: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // Single parameter copy, shared by every initiator
    logic        keep_arbitration_wait_running_r;
    logic        bcast_en_r;
    logic        indicator_polarity_select_r;
    logic [15:0] nexus_time_r;
    logic [15:0] initiator_data_timeout_r;
    logic [15:0] retry_holdoff_limit_r;

    // Timer state
    pscp_tmr_t   arb_st_r;
    logic [15:0] arb_cnt_r;
    pscp_tmr_t   nx_st_r;
    logic [15:0] nx_cnt_r;
    pscp_tmr_t   dt_st_r;
    logic [15:0] dt_cnt_r;
    pscp_tmr_t   ho_st_r;
    logic [15:0] ho_cnt_r;
    logic        cmd_abort_r;
    logic        async_event_r;
    logic        ready_led_r;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic        aw_have_r;
    logic [7:0]  aw_addr_r;
    logic        w_have_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        do_write;

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready  = !w_have_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign do_write      = aw_have_r && w_have_r && !bvalid_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Parameter fields
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            keep_arbitration_wait_running_r <= KEEP_ARB_RST;
            bcast_en_r                      <= BCAST_EN_RST;
            indicator_polarity_select_r     <= IND_POL_RST;
            nexus_time_r                    <= NEXUS_TIME_RST;
            initiator_data_timeout_r        <= DATA_TIMEOUT_RST;
            retry_holdoff_limit_r           <= HOLDOFF_RST;
        end else if (do_write) begin
            if (aw_addr_r == OFS_PORT_HDR && w_strb_r[2]) begin
                keep_arbitration_wait_running_r <= w_data_r[BIT_KEEP_ARB];
                bcast_en_r                      <= w_data_r[BIT_BCAST_EN];
                indicator_polarity_select_r     <= w_data_r[BIT_IND_POL];
            end
            if (aw_addr_r == OFS_PORT_TIME) begin
                if (w_strb_r[0]) nexus_time_r[7:0]              <= w_data_r[7:0];
                if (w_strb_r[1]) nexus_time_r[15:8]             <= w_data_r[15:8];
                if (w_strb_r[2]) initiator_data_timeout_r[7:0]  <= w_data_r[23:16];
                if (w_strb_r[3]) initiator_data_timeout_r[15:8] <= w_data_r[31:24];
            end
            if (aw_addr_r == OFS_PORT_HOLD) begin
                if (w_strb_r[0]) retry_holdoff_limit_r[7:0]  <= w_data_r[7:0];
                if (w_strb_r[1]) retry_holdoff_limit_r[15:8] <= w_data_r[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] rd_mux;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            OFS_PORT_HDR: begin
                rd_mux[7:0]   = {PORT_PS, PORT_SPF, PORT_PAGE_CODE};
                rd_mux[15:8]  = PORT_PAGE_LEN;
                rd_mux[23:16] = {1'b0, keep_arbitration_wait_running_r, bcast_en_r,
                                 indicator_polarity_select_r, PROTO_TAG};
            end
            OFS_PORT_TIME: rd_mux = {initiator_data_timeout_r, nexus_time_r};
            OFS_PORT_HOLD: rd_mux[15:0] = retry_holdoff_limit_r;
            OFS_LU_PAGE: begin
                rd_mux[7:0]   = {LU_PS, LU_SPF, LU_PAGE_CODE};
                rd_mux[15:8]  = LU_PAGE_LEN;
                rd_mux[23:16] = {2'b00, LU_LINK_RETRY, PROTO_TAG[2:0]};
            end
            OFS_STATUS: rd_mux[4:0] = {ready_led_r, ho_st_r == ST_RUN,
                                       dt_st_r == ST_RUN, nx_st_r == ST_DONE, arb_st_r == ST_RUN};
            OFS_ARB_TIMER: rd_mux[15:0] = arb_cnt_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Arbitration wait timer, 10 us units
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            arb_st_r  <= ST_IDLE;
            arb_cnt_r <= 16'h0000;
        end else if (arb_start) begin
            arb_st_r  <= ST_RUN;
            arb_cnt_r <= 16'h0000;
        end else if (rej_retry && !keep_arbitration_wait_running_r) begin
            arb_st_r  <= ST_IDLE;
            arb_cnt_r <= 16'h0000;
        end else if (conn_opened) begin
            arb_st_r <= ST_IDLE;
        end else begin
            // A retry reject with the keep bit set falls through here
            case (arb_st_r)
                ST_RUN: begin
                    if (tk.us10_tick && arb_cnt_r != 16'hFFFF) begin
                        arb_cnt_r <= arb_cnt_r + 16'h0001;
                    end
                end
                ST_IDLE, ST_DONE: arb_st_r <= arb_st_r;
                default: arb_st_r <= ST_IDLE;
            endcase
        end
    end

    assign arb_wait_time = arb_cnt_r;

    // ------------------------------------------------------------
    // Nexus loss timer, ms units
    // ------------------------------------------------------------
    logic [15:0] nx_limit;
    assign nx_limit = (nexus_time_r == 16'h0000) ? NEXUS_ZERO_MS : nexus_time_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            nx_st_r  <= ST_IDLE;
            nx_cnt_r <= 16'h0000;
        end else if (conn_opened) begin
            nx_st_r  <= ST_IDLE;
            nx_cnt_r <= 16'h0000;
        end else begin
            case (nx_st_r)
                ST_IDLE: begin
                    if (rej_absent) begin
                        nx_st_r  <= ST_RUN;
                        nx_cnt_r <= 16'h0000;
                    end
                end
                ST_RUN: begin
                    if (nexus_time_r != NEXUS_UNLIMITED && nx_cnt_r >= nx_limit) begin
                        nx_st_r <= ST_DONE;
                    end else if (tk.ms_tick && nx_cnt_r != 16'hFFFF) begin
                        nx_cnt_r <= nx_cnt_r + 16'h0001;
                    end
                end
                ST_DONE: nx_st_r <= ST_DONE;
                default: nx_st_r <= ST_IDLE;
            endcase
        end
    end

    assign nexus_lost = (nx_st_r == ST_DONE);

    // ------------------------------------------------------------
    // Initiator data wait timer, ms units
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            dt_st_r     <= ST_IDLE;
            dt_cnt_r    <= 16'h0000;
            cmd_abort_r <= 1'b0;
        end else begin
            cmd_abort_r <= 1'b0;
            if (xfer_rdy_sent && initiator_data_timeout_r != 16'h0000) begin
                dt_st_r  <= ST_RUN;
                dt_cnt_r <= 16'h0000;
            end else if (data_frame_rx || initiator_data_timeout_r == 16'h0000) begin
                dt_st_r <= ST_IDLE;
            end else begin
                case (dt_st_r)
                    ST_RUN: begin
                        if (dt_cnt_r >= initiator_data_timeout_r) begin
                            dt_st_r     <= ST_IDLE;
                            cmd_abort_r <= 1'b1;
                        end else if (tk.ms_tick) begin
                            dt_cnt_r <= dt_cnt_r + 16'h0001;
                        end
                    end
                    ST_IDLE, ST_DONE: dt_st_r <= ST_IDLE;
                    default: dt_st_r <= ST_IDLE;
                endcase
            end
        end
    end

    assign cmd_abort = cmd_abort_r;

    // ------------------------------------------------------------
    // Reject-to-open holdoff, 10 us units
    // ------------------------------------------------------------
    logic [15:0] ho_limit;
    assign ho_limit = (retry_holdoff_limit_r == 16'h0000) ? HOLDOFF_ZERO_MIN
                                                         : retry_holdoff_limit_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ho_st_r  <= ST_IDLE;
            ho_cnt_r <= 16'h0000;
        end else if (rej_retry || rej_continue) begin
            ho_st_r  <= ST_RUN;
            ho_cnt_r <= 16'h0000;
        end else begin
            case (ho_st_r)
                ST_RUN: begin
                    // First tick is partial, so release only at tick limit+1
                    if (tk.us10_tick && ho_cnt_r >= ho_limit) begin
                        ho_st_r <= ST_IDLE;
                    end else if (tk.us10_tick) begin
                        ho_cnt_r <= ho_cnt_r + 16'h0001;
                    end
                end
                ST_IDLE, ST_DONE: ho_st_r <= ST_IDLE;
                default: ho_st_r <= ST_IDLE;
            endcase
        end
    end

    assign conn_req_allow = (ho_st_r != ST_RUN) && !nexus_lost;

    // ------------------------------------------------------------
    // Broadcast origination and ready indicator
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            async_event_r <= 1'b0;
        end else begin
            async_event_r <= async_event_req && bcast_en_r;
        end
    end

    assign async_event_send = async_event_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ready_led_r <= 1'b0;
        end else if (indicator_polarity_select_r) begin
            ready_led_r <= cmd_active && tk.blink;
        end else begin
            ready_led_r <= drive_ready && !(cmd_active && tk.blink);
        end
    end

    assign ready_led = ready_led_r;
endmodule
`default_nettype wire

// >>> rtl/pscp_pkg.sv
// Purpose : Shared constants for the port control parameter block
// Assumes : 50 MHz clock, 32-bit AXI4-Lite register bus
// Notes   : All offsets are byte addresses of aligned words
package pscp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_HDR   = 8'h00;
    localparam logic [7:0] OFS_PORT_TIME  = 8'h04;
    localparam logic [7:0] OFS_PORT_HOLD  = 8'h08;
    localparam logic [7:0] OFS_PORT_RSVD  = 8'h0C;
    localparam logic [7:0] OFS_LU_PAGE    = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;
    localparam logic [7:0] OFS_ARB_TIMER  = 8'h18;

    // ------------------------------------------------------------
    // Page constants
    // ------------------------------------------------------------
    localparam logic [5:0] PORT_PAGE_CODE = 6'h19;
    localparam logic [7:0] PORT_PAGE_LEN  = 8'h0E;
    localparam logic [5:0] LU_PAGE_CODE   = 6'h18;
    localparam logic [7:0] LU_PAGE_LEN    = 8'h06;
    localparam logic [3:0] PROTO_TAG      = 4'h6;
    localparam logic       PORT_PS        = 1'b1;
    localparam logic       PORT_SPF       = 1'b0;
    localparam logic       LU_PS          = 1'b0;
    localparam logic       LU_SPF         = 1'b0;
    localparam logic [2:0] LU_LINK_RETRY  = 3'h0;

    // ------------------------------------------------------------
    // Field positions in the header word
    // ------------------------------------------------------------
    localparam int BIT_KEEP_ARB  = 22;
    localparam int BIT_BCAST_EN  = 21;
    localparam int BIT_IND_POL   = 20;

    // ------------------------------------------------------------
    // Reset values and special codes
    // ------------------------------------------------------------
    localparam logic [15:0] NEXUS_TIME_RST   = 16'h07D0;
    localparam logic [15:0] DATA_TIMEOUT_RST = 16'h07D0;
    localparam logic [15:0] HOLDOFF_RST      = 16'h0000;
    localparam logic        KEEP_ARB_RST     = 1'b0;
    localparam logic        BCAST_EN_RST     = 1'b0;
    localparam logic        IND_POL_RST      = 1'b0;
    localparam logic [15:0] NEXUS_UNLIMITED  = 16'hFFFF;
    localparam logic [15:0] NEXUS_ZERO_MS    = 16'h07D0;
    localparam logic [15:0] HOLDOFF_ZERO_MIN = 16'h0001;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_US10_NS  = 10000;
    localparam int TICK_MS_NS    = 1000000;
    localparam int CYC_PER_US10  = TICK_US10_NS / CLK_PERIOD_NS;
    localparam int US10_PER_MS   = TICK_MS_NS / TICK_US10_NS;
    localparam int BLINK_HALF_MS = 64;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} pscp_tmr_t;
endpackage

// >>> rtl/pscp_tick_if.sv
// Purpose : Carries timing ticks from the prescaler to the port logic
// Assumes : Single clock domain
// Notes   : Ticks are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface pscp_tick_if;
    logic us10_tick;
    logic ms_tick;
    logic blink;
    modport src (output us10_tick, output ms_tick, output blink);
    modport snk (input us10_tick, input ms_tick, input blink);
endinterface
`default_nettype wire

// >>> rtl/pscp_tick_gen.sv
// Purpose : Prescaler for 10 us and 1 ms ticks and the indicator blink
// Assumes : 50 MHz clock
// Notes   : Free running from reset
`timescale 1ns/1ps
`default_nettype none
module pscp_tick_gen (
    input  wire logic  clk,
    input  wire logic  rst,
    pscp_tick_if.src   tk
);
    import pscp_pkg::*;

    logic [9:0] cyc_r;
    logic [6:0] us10_r;
    logic [6:0] ms_r;
    logic       us10_r_tick;
    logic       ms_r_tick;
    logic       blink_r;

    // ------------------------------------------------------------
    // 10 us prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_r       <= 10'h000;
            us10_r_tick <= 1'b0;
        end else if (cyc_r == 10'(CYC_PER_US10 - 1)) begin
            cyc_r       <= 10'h000;
            us10_r_tick <= 1'b1;
        end else begin
            cyc_r       <= cyc_r + 10'h001;
            us10_r_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // 1 ms prescaler and blink
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            us10_r    <= 7'h00;
            ms_r_tick <= 1'b0;
        end else if (us10_r_tick && us10_r == 7'(US10_PER_MS - 1)) begin
            us10_r    <= 7'h00;
            ms_r_tick <= 1'b1;
        end else begin
            if (us10_r_tick) begin
                us10_r <= us10_r + 7'h01;
            end
            ms_r_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ms_r    <= 7'h00;
            blink_r <= 1'b0;
        end else if (ms_r_tick) begin
            if (ms_r == 7'(BLINK_HALF_MS - 1)) begin
                ms_r    <= 7'h00;
                blink_r <= ~blink_r;
            end else begin
                ms_r <= ms_r + 7'h01;
            end
        end
    end

    assign tk.us10_tick = us10_r_tick;
    assign tk.ms_tick   = ms_r_tick;
    assign tk.blink     = blink_r;
endmodule
`default_nettype wire

// >>> testbench/pscp_port_ctl_monitor.sv
// Purpose: Port-level checks for the parameter block
// Assumes: Sees top-level ports only
// Notes  : Bound into every instance below
`timescale 1ns/1ps
`default_nettype none
module pscp_port_ctl_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        arb_start,
    input wire logic [15:0] arb_wait_time,
    input wire logic        rej_retry,
    input wire logic        conn_opened,
    input wire logic        nexus_lost,
    input wire logic        cmd_abort,
    input wire logic        conn_req_allow,
    input wire logic        async_event_req,
    input wire logic        async_event_send
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_rst_idle: assert property ($past(rst) |-> conn_req_allow && !cmd_abort) else $error("reset");
    a_bcast_cause: assert property (async_event_send |-> $past(async_event_req)) else $error("bcast");
    a_hold_drop: assert property (rej_retry |=> !conn_req_allow) else $error("holdoff");
    a_hold_min: assert property ($fell(conn_req_allow) && !nexus_lost |-> !conn_req_allow [*8]) else $error("min");
    a_abort_pulse: assert property (cmd_abort |=> !cmd_abort) else $error("abort");
    a_arb_restart: assert property (arb_start |=> arb_wait_time <= 16'h0001) else $error("arb");
    a_nexus_clear: assert property (conn_opened |=> !nexus_lost) else $error("nexus");
    a_nexus_block: assert property (nexus_lost |-> !conn_req_allow) else $error("block");
    c_abort: cover property (cmd_abort);
    c_bcast: cover property (async_event_send);
    c_allow: cover property ($rose(conn_req_allow));
endmodule
bind pscp_port_ctl pscp_port_ctl_monitor i_mon (.*);
`default_nettype wire

// >>> testbench/pscp_init_model.sv
// Purpose: Initiator port stand-in
// Assumes: act held one cycle by the bench
// Notes  : Each reply is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module pscp_init_model (
    input  wire logic       clk,
    input  wire logic [2:0] act,
    output logic            rej_retry,
    output logic            rej_continue,
    output logic            rej_absent,
    output logic            conn_opened
);
    always_ff @(posedge clk) begin
        rej_retry    <= act == 3'h1;
        rej_continue <= act == 3'h2;
        rej_absent   <= act == 3'h3;
        conn_opened  <= act == 3'h4;
    end
endmodule
`default_nettype wire

// >>> testbench/tb_pscp_port_ctl.sv
// Purpose: Self-checking bench for the parameter block
// Assumes: 50 MHz clock, reset held 4 cycles
// Notes  : Reads compared with word model m
`timescale 1ns/1ps
`default_nettype none
module tb_pscp_port_ctl;
    import pscp_pkg::*;
    logic        clk = 1'h0, rst = 1'h1, drive_ready = 1'h0, cmd_active = 1'h0, data_frame_rx = 1'h0;
    logic        arb_start = 1'h0, xfer_rdy_sent = 1'h0, async_event_req = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, rej_retry, rej_continue, rej_absent;
    logic        conn_opened, nexus_lost, cmd_abort, conn_req_allow, async_event_send, ready_led;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  act = 3'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] arb_wait_time;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, v, m [0:7];
    int          fail_count = 0, samples_checked = 0, n;
    pscp_port_ctl   i_dut (.*);
    pscp_init_model i_ini (.*);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic ok, input string s);
        samples_checked++;
        if (ok !== 1'h1) begin
            fail_count++;
            $display("BAD %0t %s", $time, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (n = 0; n < 60 && !(s_axi_bvalid && s_axi_bready); n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        chk(s_axi_bvalid && s_axi_bresp === e, "write");
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        for (n = 0; n < 60 && !(s_axi_rvalid && s_axi_rready); n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        chk(s_axi_rvalid && s_axi_rdata === d && s_axi_rresp === e, "read");
        @(posedge clk);
    endtask
    // Far-side reply: pulse reaches the block two edges later
    task automatic ini(input logic [2:0] k);
        act <= k;
        @(posedge clk);
        act <= 3'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        r = $urandom(32'h291A);
        m = '{32'h00060E99, 32'h07D007D0, 32'h0, 32'h0, 32'h00060618, 32'h0, 32'h0, 32'h0};
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 7; k++) rd(8'(4 * k), m[k], RESP_OKAY);
            rd(8'h1C, 32'h0, RESP_SLVERR);
            r = $urandom;
            wr(8'h1C, r, RESP_SLVERR);
            wr(OFS_LU_PAGE, r, RESP_OKAY);
            wr(OFS_PORT_RSVD, r, RESP_OKAY);
            wr(OFS_PORT_HDR, r, RESP_OKAY);
            m[0] = 32'h00060E99 | (r & 32'h00700000);
            r = $urandom;
            wr(OFS_PORT_TIME, r, RESP_OKAY);
            m[1] = r;
            wr(OFS_PORT_HOLD, r, RESP_OKAY);
            m[2] = r & 32'h0000FFFF;
        end
        $display("test registers done");
        drive_ready <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            wr(OFS_PORT_HDR, 32'(k * 3) << 20, RESP_OKAY);
            async_event_req <= 1'h1;
            cmd_active      <= 1'(k);
            @(posedge clk);
            async_event_req <= 1'h0;
            @(posedge clk);
            chk(async_event_send === 1'(k), "broadcast");
            repeat (4) @(posedge clk);
            chk(ready_led === 1'(1 - k), "indicator");
        end
        $display("test broadcast and indicator done");
        for (int k = 0; k < 2; k++) begin
            wr(OFS_PORT_HDR, 32'(k) << 22, RESP_OKAY);
            arb_start <= 1'h1;
            @(posedge clk);
            arb_start <= 1'h0;
            repeat (1100) @(posedge clk);
            v = 32'(arb_wait_time);
            chk(v >= 2, "arbitration count");
            ini(3'h1);
            chk(k ? arb_wait_time >= v[15:0] : arb_wait_time === 16'h0, "arbitration reject");
        end
        $display("test arbitration done");
        wr(OFS_PORT_HOLD, 32'h2, RESP_OKAY);
        ini(3'h2);
        for (n = 0; n < 2000 && conn_req_allow !== 1'h1; n++) @(posedge clk);
        chk(n >= 1000 && n <= 1500, "holdoff length");
        $display("test holdoff done");
        wr(OFS_PORT_TIME, 32'h0064FFFF, RESP_OKAY);
        xfer_rdy_sent <= 1'h1;
        @(posedge clk);
        xfer_rdy_sent <= 1'h0;
        rd(OFS_STATUS, 32'h15, RESP_OKAY);
        data_frame_rx <= 1'h1;
        @(posedge clk);
        data_frame_rx <= 1'h0;
        rd(OFS_STATUS, 32'h11, RESP_OKAY);
        wr(OFS_PORT_TIME, 32'h0001FFFF, RESP_OKAY);
        ini(3'h3);
        xfer_rdy_sent <= 1'h1;
        @(posedge clk);
        xfer_rdy_sent <= 1'h0;
        for (n = 0; n < 50010 && cmd_abort !== 1'h1; n++) @(posedge clk);
        chk(n <= 50005, "data wait abort");
        chk(nexus_lost === 1'h0, "nexus unlimited");
        wr(OFS_PORT_TIME, 32'h00010001, RESP_OKAY);
        @(posedge clk);
        chk(nexus_lost === 1'h1 && conn_req_allow === 1'h0, "nexus loss");
        ini(3'h4);
        chk(nexus_lost === 1'h0 && conn_req_allow === 1'h1, "nexus cleared");
        $display("test timers done");
        finish_test();
    end
endmodule
`default_nettype wire
